//--- cpbc_consts.svh
/*
 * constants for the programmable can buffer control block: register offsets,
 * control field positions, interrupt layout and reset values.
 * assumes inclusion by bare name from package and modules.
 */
`ifndef CPBC_CONSTS_SVH
`define CPBC_CONSTS_SVH

`define CPBC_NUM_BUF 6
// register byte offsets
`define CPBC_OFS_BUF0 12'h000
`define CPBC_OFS_DIR 12'h018
`define CPBC_OFS_MODE 12'h01C
`define CPBC_OFS_STAT 12'h020
`define CPBC_OFS_MASK 12'h024
// control field positions
`define CPBC_RX_FULL 7
`define CPBC_RX_ALL 6
`define CPBC_RX_RTR 5
`define CPBC_TX_DONE 7
`define CPBC_TX_ABT 6
`define CPBC_TX_LARB 5
`define CPBC_TX_ERR 4
`define CPBC_TX_REQ 3
`define CPBC_TX_AUTO_REMOTE_REPLY_ENABLE 2
// interrupt status layout: rx stored [5:0], tx done [11:6], tx abort [17:12]
`define CPBC_IRQ_W 18
`define CPBC_CTL_RST 8'h00
`define CPBC_MODE_RST 2'h0

`endif

//--- cpbc_pkg.sv
/*
 * types of the programmable can buffer control block.
 * assumes cpbc_consts.svh on the include path.
 */
`include "cpbc_consts.svh"

package cpbc_pkg;

   // frame delivered by the protocol engine
   typedef struct packed {
      logic valid;
      logic ok;
      logic accepted;
      logic remote;
      logic [4:0] filter;
   } cpbc_rx_t;

   // outcome of an attempted send
   typedef struct packed {
      logic done;
      logic success;
      logic lost_arb;
      logic error;
   } cpbc_txres_t;

   // request to the protocol engine
   typedef struct packed {
      logic start;
      logic [2:0] index;
      logic remote_reply;
   } cpbc_tx_request_bit_t;

   typedef enum logic [1:0] {
      CPBC_TX_IDLE,
      CPBC_TX_BUSY
   } cpbc_txst_t;

endpackage : cpbc_pkg

//--- cpbc_tx_arbiter.sv
/*
 * picks the pending transmit buffer with the highest priority; on a tie the
 * lowest index wins.
 * assumes request and priority vectors from the same clock domain.
 */
`timescale 1ns/1ps
`include "cpbc_consts.svh"

module cpbc_tx_arbiter
   import cpbc_pkg::*;
(
   input wire logic [`CPBC_NUM_BUF-1:0] req,
   input wire logic [2*`CPBC_NUM_BUF-1:0] pri,
   output logic found,
   output logic [2:0] index
);

   // scan from the top so lower indexes overwrite on equal priority
   always_comb begin
      logic [1:0] best;
      best = 2'h0;
      found = 1'b0;
      index = 3'h0;
      for (int i = `CPBC_NUM_BUF - 1; i >= 0; i--) begin
         if (req[i] && (!found || pri[2*i +: 2] >= best)) begin
            found = 1'b1;
            best = pri[2*i +: 2];
            index = 3'(i);
         end
      end
   end

endmodule : cpbc_tx_arbiter

//--- cpbc_buffer_ctrl.sv
/*
 * control and status of six can message buffers, reached over ahb-lite.
 * assumes a protocol engine on hclk that offers received frames, remote
 * requests and send results, and takes one send request at a time.
 */
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "cpbc_consts.svh"

module cpbc_buffer_ctrl
   import cpbc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire cpbc_rx_t rx_frame,
   input wire logic [2:0] rx_index,
   input wire logic [10:0] remote_id,
   input wire logic remote_seen,
   input wire logic [10:0] buf_id [`CPBC_NUM_BUF],
   input wire cpbc_txres_t tx_result,
   output cpbc_tx_request_bit_t tx_request,
   output logic [`CPBC_NUM_BUF-1:0] rx_stored,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   // register map, one word each, data in the low bits
   //   buffer n control at n*4 (n 0..5), a byte whose layout follows the
   //   direction bit of that buffer:
   //     receive view: full, accept-all, remote, filter index [4:0]
   //     transmit view: done, aborted, lost arbitration, error, request,
   //     auto reply, priority [1:0]
   //   direction word: bit n set makes buffer n a transmit buffer
   //   mode word: two bits, zero parks every buffer
   //   status word: rx stored [5:0], tx done [11:6], tx aborted [17:12],
   //   write one to clear, a new event wins over the clear
   //   mask word: same layout, any unmasked status bit raises irq
   // hazards a user must know
   //   writes are posted: a read in the very next address phase sees the old value
   //   lost arbitration and bus errors keep the request and retry at once
   //   a buffer cannot change direction while it is queued or on the wire
   typedef struct packed {
      logic [`CPBC_NUM_BUF-1:0][7:0] ctl;
      logic [`CPBC_NUM_BUF-1:0] dir;
      logic [1:0] mode;
      logic [`CPBC_IRQ_W-1:0] stat;
      logic [`CPBC_IRQ_W-1:0] mask;
      logic [`CPBC_NUM_BUF-1:0] rtr_pend;
      cpbc_txst_t txst;
      logic [2:0] cur;
      logic cur_rtr;
      cpbc_tx_request_bit_t tx_request_bit;
      logic [`CPBC_NUM_BUF-1:0] stored;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic irq;
   } cpbc_state_t;

   cpbc_state_t st_r;
   cpbc_state_t st_nxt;

   logic arb_found;
   logic [2:0] arb_index;
   logic [`CPBC_NUM_BUF-1:0] tx_pend;
   logic [2*`CPBC_NUM_BUF-1:0] tx_pri;

   ////////////////////////////////////////////////////////////////////////////
   // pending requests and priorities for the arbiter

   generate
      for (genvar g = 0; g < `CPBC_NUM_BUF; g++) begin : g_pend
         assign tx_pend[g] = st_r.dir[g] && (st_r.ctl[g][`CPBC_TX_REQ] || st_r.rtr_pend[g]);
         assign tx_pri[2*g +: 2] = st_r.ctl[g][1:0];
      end
   endgenerate

   cpbc_tx_arbiter u_arb (
      .req(tx_pend),
      .pri(tx_pri),
      .found(arb_found),
      .index(arb_index)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic active;
      logic addr_ok;
      logic [7:0] wb;
      logic [`CPBC_IRQ_W-1:0] ev;
      logic busy;
      logic [2:0] bi;
      logic lock;
      active = (st_r.mode != 2'h0);
      addr_ok = hsel && hready && htrans[1];
      wb = hwdata[7:0];
      ev = '0;
      busy = 1'b0;
      bi = 3'h0;
      lock = 1'b0;
      st_nxt = st_r;
      st_nxt.tx_request_bit.start = 1'b0;
      st_nxt.stored = '0;

      // data phase of a posted write
      if (st_r.wr_pend) begin
         st_nxt.wr_pend = 1'b0;
         if (st_r.wr_addr < `CPBC_OFS_DIR && st_r.wr_addr[1:0] == 2'h0) begin
            bi = st_r.wr_addr[4:2];
            busy = (st_r.txst == CPBC_TX_BUSY) && (st_r.cur == bi);
            if (active && !st_r.dir[bi]) begin
               // receive view: clear-only full flag, writable accept-all
               if (!wb[`CPBC_RX_FULL])
                  st_nxt.ctl[bi][`CPBC_RX_FULL] = 1'b0;
               st_nxt.ctl[bi][`CPBC_RX_ALL] = wb[`CPBC_RX_ALL];
            end else if (active) begin
               // transmit view: done flag writable, control fields locked while busy
               st_nxt.ctl[bi][`CPBC_TX_DONE] = wb[`CPBC_TX_DONE];
               if (!st_r.ctl[bi][`CPBC_TX_REQ] && !busy) begin
                  st_nxt.ctl[bi][2:0] = wb[2:0];
                  if (wb[`CPBC_TX_REQ]) begin
                     st_nxt.ctl[bi][`CPBC_TX_REQ] = 1'b1;
                     st_nxt.ctl[bi][`CPBC_TX_LARB] = 1'b0;
                     st_nxt.ctl[bi][`CPBC_TX_ERR] = 1'b0;
                     st_nxt.ctl[bi][`CPBC_TX_ABT] = 1'b0;
                  end
               end else if (st_r.ctl[bi][`CPBC_TX_REQ] && !wb[`CPBC_TX_REQ]) begin
                  // clearing a pending request asks for an abort
                  st_nxt.ctl[bi][`CPBC_TX_REQ] = 1'b0;
                  st_nxt.ctl[bi][`CPBC_TX_ABT] = 1'b1;
                  ev[12 + 32'(bi)] = 1'b1;
               end
            end
         end else if (st_r.wr_addr == `CPBC_OFS_DIR) begin
            // direction may only change on idle buffers: a send in flight would
            // otherwise land its done flag in the receive view as a full flag
            for (int i = 0; i < `CPBC_NUM_BUF; i++) begin
               lock = st_r.dir[i] && (st_r.ctl[i][`CPBC_TX_REQ] || st_r.rtr_pend[i]
                      || (st_r.txst == CPBC_TX_BUSY && st_r.cur == 3'(i)));
               if (!lock)
                  st_nxt.dir[i] = hwdata[i];
               if (st_nxt.dir[i] != st_r.dir[i]) begin
                  // a fresh view starts clean and forgets queued replies
                  st_nxt.ctl[i] = `CPBC_CTL_RST;
                  st_nxt.rtr_pend[i] = 1'b0;
               end
            end
         end else if (st_r.wr_addr == `CPBC_OFS_MODE) begin
            st_nxt.mode = hwdata[1:0];
         end else if (st_r.wr_addr == `CPBC_OFS_STAT) begin
            st_nxt.stat = st_r.stat & ~hwdata[`CPBC_IRQ_W-1:0];
         end else if (st_r.wr_addr == `CPBC_OFS_MASK) begin
            st_nxt.mask = hwdata[`CPBC_IRQ_W-1:0];
         end
      end

      // receive path from the protocol engine
      if (active && rx_frame.valid && rx_index < 3'(`CPBC_NUM_BUF)) begin
         bi = rx_index;
         // a buffer turning to transmit in this cycle takes no frame
         if (!st_r.dir[bi] && !st_nxt.dir[bi]
             && !st_r.ctl[bi][`CPBC_RX_FULL]) begin
            if (st_r.ctl[bi][`CPBC_RX_ALL] || (rx_frame.ok && rx_frame.accepted)) begin
               st_nxt.ctl[bi][`CPBC_RX_FULL] = 1'b1;
               st_nxt.ctl[bi][`CPBC_RX_RTR] = rx_frame.remote;
               st_nxt.ctl[bi][4:0] = rx_frame.filter;
               st_nxt.stored[bi] = 1'b1;
               ev[bi] = 1'b1;
            end
         end
      end

      // remote request matching an auto-reply transmit buffer
      for (int i = 0; i < `CPBC_NUM_BUF; i++) begin
         if (active && remote_seen && st_r.dir[i] && st_nxt.dir[i]
             && st_r.ctl[i][`CPBC_TX_AUTO_REMOTE_REPLY_ENABLE] && buf_id[i] == remote_id)
            st_nxt.rtr_pend[i] = 1'b1;
      end

      // transmit sequencing
      unique case (st_r.txst)
         CPBC_TX_IDLE: begin
            if (active && arb_found) begin
               st_nxt.txst = CPBC_TX_BUSY;
               st_nxt.cur = arb_index;
               st_nxt.cur_rtr = !st_r.ctl[arb_index][`CPBC_TX_REQ];
               st_nxt.tx_request_bit.start = 1'b1;
               st_nxt.tx_request_bit.index = arb_index;
               st_nxt.tx_request_bit.remote_reply = !st_r.ctl[arb_index][`CPBC_TX_REQ];
            end
         end
         CPBC_TX_BUSY: begin
            if (tx_result.done) begin
               st_nxt.txst = CPBC_TX_IDLE;
               bi = st_r.cur;
               if (tx_result.success) begin
                  st_nxt.ctl[bi][`CPBC_TX_REQ] = 1'b0;
                  st_nxt.ctl[bi][`CPBC_TX_DONE] = 1'b1;
                  st_nxt.rtr_pend[bi] = 1'b0;
                  ev[6 + 32'(bi)] = 1'b1;
               end else begin
                  st_nxt.ctl[bi][`CPBC_TX_LARB] = tx_result.lost_arb;
                  st_nxt.ctl[bi][`CPBC_TX_ERR] = tx_result.error;
                  if (st_r.cur_rtr && !st_r.ctl[bi][`CPBC_TX_AUTO_REMOTE_REPLY_ENABLE])
                     st_nxt.rtr_pend[bi] = 1'b0;
               end
            end
         end
      endcase

      // events win over a same-cycle clear
      st_nxt.stat = st_nxt.stat | ev;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

      // address phase: reads answer next cycle, writes are posted
      if (addr_ok) begin
         st_nxt.wr_pend = hwrite;
         st_nxt.wr_addr = haddr;
         st_nxt.rdata = 32'h0000_0000;
         if (!hwrite) begin
            if (haddr < `CPBC_OFS_DIR && haddr[1:0] == 2'h0)
               st_nxt.rdata = {24'h00_0000, active ? st_r.ctl[haddr[4:2]] : 8'h00};
            else if (haddr == `CPBC_OFS_DIR)
               st_nxt.rdata = {26'h000_0000, st_r.dir};
            else if (haddr == `CPBC_OFS_MODE)
               st_nxt.rdata = {30'h0000_0000, st_r.mode};
            else if (haddr == `CPBC_OFS_STAT)
               st_nxt.rdata = {14'h0000, st_r.stat};
            else if (haddr == `CPBC_OFS_MASK)
               st_nxt.rdata = {14'h0000, st_r.mask};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign hrdata = st_r.rdata;
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // always okay
   assign tx_request = st_r.tx_request_bit;
   assign rx_stored = st_r.stored;
   assign irq = st_r.irq;

endmodule : cpbc_buffer_ctrl

//--- cpbc_buffer_ctrl_props.sv
/*
 * checker of the buffer control block at its top ports.
 * assumes hclk and active low hresetn of one domain.
 */
`timescale 1ns/1ps
`include "cpbc_consts.svh"

module cpbc_props
   import cpbc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire cpbc_rx_t rx_frame,
   input wire logic [2:0] rx_index,
   input wire logic [10:0] remote_id,
   input wire logic remote_seen,
   input wire logic [10:0] buf_id [`CPBC_NUM_BUF],
   input wire cpbc_txres_t tx_result,
   input wire cpbc_tx_request_bit_t tx_request,
   input wire logic [`CPBC_NUM_BUF-1:0] rx_stored,
   input wire logic irq
);
   logic busy_r;
   logic mwr_r;
   logic unm_r;
   logic [1:0] mode_r;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // follow mode writes, the open send and reads of an unmapped word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_r <= 1'b0;
         mwr_r <= 1'b0;
         unm_r <= 1'b0;
         mode_r <= 2'h0;
      end else begin
         mwr_r <= hsel && hready && htrans[1] && hwrite && haddr == `CPBC_OFS_MODE;
         unm_r <= hsel && hready && htrans[1] && !hwrite && haddr == 12'hFFC;
         if (mwr_r) mode_r <= hwdata[1:0];
         if (tx_request.start) busy_r <= 1'b1;
         else if (tx_result.done) busy_r <= 1'b0;
      end
   end
   sequence s_start;
      tx_request.start;
   endsequence
   sequence s_quiet;
      !tx_request.start;
   endsequence
   zero_wait_a: assert property (hreadyout) else $error("wait state inserted");
   resp_okay_a: assert property (!hresp) else $error("error response");
   start_pulse_a: assert property (s_start |=> s_quiet) else $error("start too long");
   one_send_a: assert property (s_start |-> !busy_r) else $error("second send");
   store_cause_a: assert property (rx_stored != 0 |-> $past(rx_frame.valid)
      && rx_stored == 6'(1 << $past(rx_index))) else $error("stray store");
   mode_rx_a: assert property (mode_r == 0 && rx_frame.valid |=> rx_stored == 0)
      else $error("store in mode 0");
   mode_tx_a: assert property (s_start |-> $past(mode_r) != 0)
      else $error("send in mode 0");
   unmapped_rd_a: assert property (unm_r |-> hrdata == 0) else $error("unmapped data");
endmodule : cpbc_props

bind cpbc_buffer_ctrl cpbc_props u_cpbc_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_frame, .rx_index,
   .remote_id, .remote_seen, .buf_id, .tx_result, .tx_request, .rx_stored, .irq);

//--- cpbc_engine_model.sv
/*
 * protocol engine stand-in: takes one send and ends it with a result pulse.
 * assumes start pulses on hclk.
 */
`timescale 1ns/1ps

module cpbc_engine_model
   import cpbc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire cpbc_tx_request_bit_t tx_request,
   input wire logic slow,
   input wire logic lose,
   output cpbc_txres_t tx_result
);
   int cnt;
   // answer after 40 cycles when slow, else after 2
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         tx_result <= '0;
      end else begin
         tx_result <= '0;
         if (tx_request.start) cnt <= slow ? 40 : 2;
         else if (cnt == 1) begin
            cnt <= 0;
            tx_result <= lose ? 4'hA : 4'hC; // done, lost arbitration or success
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule : cpbc_engine_model

//--- cpbc_buffer_ctrl_test.sv
/*
 * self-checking bench of the buffer control block.
 * assumes the engine model on the far side and a 200 MHz hclk.
 */
`timescale 1ns/1ps
`include "cpbc_consts.svh"

module cpbc_buffer_ctrl_test
   import cpbc_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, remote_seen, irq, slow, lose;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rdat;
   logic [10:0] remote_id;
   logic [10:0] buf_id [`CPBC_NUM_BUF];
   logic [2:0] rx_index;
   logic [5:0] rx_stored;
   logic [3:0] starts[$];
   cpbc_rx_t rx_frame;
   cpbc_txres_t tx_result;
   cpbc_tx_request_bit_t tx_request;
   int n_mismatch, n_compared;
   cpbc_buffer_ctrl u_cpbc_buffer_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .rx_frame,
      .rx_index, .remote_id, .remote_seen, .buf_id, .tx_result, .tx_request, .rx_stored,
      .irq);
   cpbc_engine_model u_cpbc_engine_model (.hclk, .hresetn, .tx_request, .slow, .lose,
      .tx_result);
   ////////////////////////////////////////////////////////////////////////////////
   // log each send start as {remote reply, index}
   always @(posedge hclk) if (tx_request.start === 1'b1)
      starts.push_back({tx_request.remote_reply, tx_request.index});
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : ahb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      chk(rdat, e);
   endtask : rd
   task automatic rxf(input cpbc_rx_t f, input logic s);
      rx_frame <= f;
      rx_index <= 3'h0;
      @(posedge hclk);
      rx_frame <= '0;
      @(posedge hclk);
      chk(rx_stored, {5'h00, s});
   endtask : rxf
   task automatic poll(input int b);
      do ahb(`CPBC_OFS_STAT, 1'b0, 32'h0); while (rdat[b] !== 1'b1);
   endtask : poll
   ////////////////////////////////////////////////////////////////////////////////
   // mode 0 silence, receive flags, filters and interrupt
   task automatic t_rx;
      ahb(12'h000, 1'b1, 32'h40);
      rd(12'h000, 32'h0);
      rd(`CPBC_OFS_MODE, 32'h0);
      rd(12'hFFC, 32'h0);
      rxf(9'h1CF, 1'b0);
      ahb(`CPBC_OFS_MODE, 1'b1, 32'h1);
      rd(12'h000, 32'h0);
      rxf(9'h1CF, 1'b1);
      rd(12'h000, 32'h8F);
      rxf(9'h1C3, 1'b0);
      rd(12'h000, 32'h8F);
      chk(irq, 1'b0);
      ahb(`CPBC_OFS_MASK, 1'b1, 32'h1);
      rd(`CPBC_OFS_STAT, 32'h1);
      chk(irq, 1'b1);
      ahb(`CPBC_OFS_STAT, 1'b1, 32'h1);
      rd(`CPBC_OFS_STAT, 32'h0);
      chk(irq, 1'b0);
      ahb(12'h000, 1'b1, 32'h0);
      rxf(9'h120, 1'b0);
      rd(12'h000, 32'h0F);
      ahb(12'h000, 1'b1, 32'h40);
      rxf(9'h120, 1'b1);
      rd(12'h000, 32'hE0);
      $display("receive test done");
   endtask : t_rx
   // start order, read-only while pending, abort and auto remote reply
   task automatic t_tx;
      ahb(`CPBC_OFS_DIR, 1'b1, 32'h0E);
      ahb(12'h00C, 1'b1, 32'h08);
      ahb(12'h004, 1'b1, 32'h09);
      ahb(12'h008, 1'b1, 32'h0B);
      ahb(12'h008, 1'b1, 32'h08);
      rd(12'h008, 32'h0B);
      ahb(12'h004, 1'b1, 32'h01);
      rd(12'h004, 32'h41);
      poll(8);
      chk(rdat, 32'h2301);
      rd(12'h00C, 32'h80);
      rd(12'h008, 32'h83);
      slow <= 1'b0;
      ahb(`CPBC_OFS_DIR, 1'b1, 32'h1E);
      ahb(12'h010, 1'b1, 32'h04);
      remote_id <= 11'h123;
      remote_seen <= 1'b1;
      @(posedge hclk);
      remote_seen <= 1'b0;
      poll(10);
      chk(starts.size(), 3);
      chk({starts[0], starts[1], starts[2]}, 12'h32C);
      $display("transmit test done");
   endtask : t_tx
   // lost arbitration keeps the request and retries, in mode 2
   task automatic t_retry;
      ahb(`CPBC_OFS_MODE, 1'b1, 32'h2);
      ahb(`CPBC_OFS_STAT, 1'b1, 32'h3FFFF);
      lose <= 1'b1;
      ahb(12'h00C, 1'b1, 32'h0A);
      repeat (8) @(posedge hclk);
      rd(12'h00C, 32'h2A);
      rd(`CPBC_OFS_STAT, 32'h0);
      lose <= 1'b0;
      poll(9);
      rd(12'h00C, 32'hA2);
      $display("retry test done");
   endtask : t_retry
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////////
   // clock, reset, stimulus and watchdog
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      stop_test;
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, remote_seen, remote_id} = '0;
      {rx_frame, rx_index, slow, lose} = 14'h2;
      foreach (buf_id[i]) buf_id[i] = 11'(i);
      buf_id[4] = 11'h123;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_rx;
      t_tx;
      t_retry;
      stop_test;
   end
endmodule : cpbc_buffer_ctrl_test
